// file: logic/lhp_pkg.sv
/*
  Constants and types shared by the host bus port of the LCD controller.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package lhp_pkg;

  // ****************************************************************
  // Address window
  // ****************************************************************
  localparam int unsigned WIN_BYTES     = 131072;        // 128 KB window
  localparam int unsigned BUF_BYTES     = 81920;         // 80 KB display buffer
  localparam int unsigned REG_BYTES     = 32;            // Control registers at the top
  localparam int unsigned BUF_WORDS     = BUF_BYTES / 2;
  localparam int unsigned REG_WORDS     = REG_BYTES / 2;
  localparam logic [15:0] BUF_LAST_WORD = 16'(BUF_WORDS - 1);
  localparam logic [15:0] REG_BASE_WORD = 16'((WIN_BYTES - REG_BYTES) / 2);

  // ****************************************************************
  // Reset-time configuration
  // ****************************************************************
  localparam logic [2:0] CFG_GENERIC = 3'h7;   // Mode pins with status low
  localparam logic [2:0] CFG_M68K    = 3'h3;   // Mode pins, status ignored
  localparam int unsigned SYNC_W     = 43;     // Pins passing the link synchroniser

  // Bus mode chosen at reset release
  typedef enum logic [1:0] {
    MODE_NONE    = 2'h0,
    MODE_GENERIC = 2'h1,
    MODE_M68K    = 2'h2
  } lhp_mode_e;

  // Host cycle sequencer, Gray coded along idle, request, done
  typedef enum logic [1:0] {
    HS_IDLE = 2'h0,
    HS_REQ  = 2'h1,
    HS_DONE = 2'h3
  } lhp_host_st_e;

endpackage : lhp_pkg

// file: logic/lhp_mem.sv
/*
  Single-port word memory with byte write enables and registered read data.
  Assumes one clock; address must be in range whenever en is high.
*/
`timescale 1ns/10ps
module lhp_mem #(
  parameter int unsigned DEPTH = 16,
  parameter int unsigned AW    = 4
) (
  // Clock
  input  wire logic          clk,
  // Access
  input  wire logic          en,
  input  wire logic [1:0]    we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [15:0]   wdata,
  output logic      [15:0]   rdata
);

  logic [15:0] mem [DEPTH];

  // ****************************************************************
  // Byte-lane writes and registered read
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (en) begin
      if (we[0]) begin
        mem[addr][7:0] <= wdata[7:0];
      end
      if (we[1]) begin
        mem[addr][15:8] <= wdata[15:8];
      end
      rdata <= mem[addr];
    end
  end

endmodule : lhp_mem

// file: logic/lhp_host_port.sv
/*
  Host bus port: generic byte-strobe mode and 68k-style strobe mode, with
  wait handshake, reset-time mode strap and arbitration against refresh.
  Assumes host pins are asynchronous to host_bus_clock only by skew; rstn
  is synchronous to clk_sys; the display refresh port is on clk_sys.
*/
`timescale 1ns/10ps
// Summary of operation
// R1: Decode 128 KB window, registers top 32 bytes.
// R2: Display buffer 80 KB from window base.
// R3: Host select writable, 16-bit, external termination.
// R4: Host uses non-boot chip select.
// R5: 68k mode: address bit zero, high write strobe.
// R6: 68k mode: low read/write enables held high.
// R7: Host lacking address strobe synthesises it.
// R8: Host side runs on dedicated bus clock.
// R9: Generic mode: host drives all address/data.
// R10: System sets endian pin for host.
// R11: Latch mode and endian pins at reset.
// R12: Select decoded from high host address.
// R13: Store only bytes with write enable low.
// R14: Return read data on enabled lanes.
// R15: Wait low until data ready or taken.
// R16: Hold wait while refresh arbitration pending.
// R17: Active-high host inverts wait output.
// R18: Status pin held low for generic mode.
// R19: Wide big-endian host uses high lanes.
// R20: Deselected: ignore strobes, release bus, wait.
module lhp_host_port
  import lhp_pkg::*;
(
  // System clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  // Host bus clock
  input  wire logic        host_bus_clock,
  // Host pins
  input  wire logic        chip_sel_n,
  input  wire logic [16:1] addr_in,
  input  wire logic        addr_bit0,
  input  wire logic        high_byte_write_n,
  input  wire logic        low_byte_write_n,
  input  wire logic        read_low_n,
  input  wire logic        read_write_n,
  input  wire logic        bus_status_n,
  input  wire logic [15:0] data_in,
  output logic      [15:0] data_out,
  output logic      [1:0]  data_oe,
  output logic             wait_n,
  output logic             wait_oe,
  // Configuration straps
  input  wire logic        endian_config_pin,
  input  wire logic        bus_mode_cfg_hi,
  input  wire logic        bus_mode_cfg_mid,
  input  wire logic        bus_mode_cfg_lo,
  // Mode status
  output logic             mode_generic,
  output logic             mode_68k,
  output logic             big_endian,
  // Display refresh port
  input  wire logic        disp_req,
  input  wire logic [15:0] disp_addr,
  output logic      [15:0] disp_data,
  output logic             disp_valid
);

  // Swap byte lanes for big-endian hosts
  function automatic logic [15:0] swap16(input logic [15:0] d, input logic sw);
    return sw ? {d[7:0], d[15:8]} : d;
  endfunction : swap16

  function automatic logic [1:0] swap2(input logic [1:0] b, input logic sw);
    return sw ? {b[0], b[1]} : b;
  endfunction : swap2

  // Buffer and register regions of the window
  function automatic logic in_buf(input logic [15:0] w);
    return w <= BUF_LAST_WORD;
  endfunction : in_buf

  function automatic logic in_reg(input logic [15:0] w);
    return w >= REG_BASE_WORD;
  endfunction : in_reg

  // ****************************************************************
  // Host domain: reset and pin synchronisers
  // ****************************************************************
  logic              hrst_meta, hrst_n;
  logic [SYNC_W-1:0] pin_meta, pin_s;
  logic              s_cs_n, s_bs_n, s_a0, s_we1_n, s_we0_n, s_rd_n, s_rw_n;
  logic [15:0]       s_addr, s_data;
  logic [3:0]        s_cfg;

  // Two flops on every pin, the first read only by the second
  always_ff @(posedge host_bus_clock) begin                    // see R8
    hrst_meta <= rstn;
    hrst_n    <= hrst_meta;
    pin_meta  <= {chip_sel_n, bus_status_n, addr_bit0, high_byte_write_n,
                  low_byte_write_n, read_low_n, read_write_n, addr_in, data_in,
                  endian_config_pin, bus_mode_cfg_hi, bus_mode_cfg_mid,
                  bus_mode_cfg_lo};
    pin_s     <= pin_meta;
  end

  assign {s_cs_n, s_bs_n, s_a0, s_we1_n, s_we0_n, s_rd_n, s_rw_n,
          s_addr, s_data, s_cfg} = pin_s;

  // ****************************************************************
  // Host domain: strap capture
  // ****************************************************************
  lhp_mode_e mode;
  logic      cfg_taken;
  logic      big;

  // Straps caught on the first edge after reset release
  always_ff @(posedge host_bus_clock) begin
    if (!hrst_n) begin
      cfg_taken <= 1'b0;
      mode      <= MODE_NONE;
      big       <= 1'b0;
    end else if (!cfg_taken) begin
      cfg_taken <= 1'b1;
      big       <= s_cfg[3];                                   // see R11
      if (s_cfg[2:0] == CFG_GENERIC && !s_bs_n) begin
        mode <= MODE_GENERIC;                                  // see R11
      end else if (s_cfg[2:0] == CFG_M68K) begin
        mode <= MODE_M68K;                                     // see R11
      end else begin
        mode <= MODE_NONE;
      end
    end
  end

  assign mode_generic = (mode == MODE_GENERIC);
  assign mode_68k     = (mode == MODE_M68K);
  assign big_endian   = big;

  // ****************************************************************
  // Host domain: cycle decode
  // ****************************************************************
  logic       cs_act, g_wr, g_rd, m_strobe, cyc, cyc_rd;
  logic [1:0] pin_be, next_be;

  // Generic uses four enables; 68k uses bit zero and high write as strobes
  always_comb begin
    cs_act   = (mode != MODE_NONE) && !s_cs_n;                 // see R20
    g_wr     = !s_we1_n || !s_we0_n;
    g_rd     = !s_rw_n || !s_rd_n;
    m_strobe = !s_bs_n && (!s_a0 || !s_we1_n);                 // see R5
    if (mode == MODE_M68K) begin
      cyc    = cs_act && m_strobe;
      cyc_rd = s_rw_n;
      pin_be = {!s_we1_n, !s_a0};                              // see R5
    end else begin
      cyc    = cs_act && (g_wr || g_rd);
      cyc_rd = !g_wr;
      pin_be = g_wr ? {!s_we1_n, !s_we0_n} : {!s_rw_n, !s_rd_n}; // see R13 R14
    end
    next_be  = swap2(pin_be, big);
  end

  // ****************************************************************
  // Host domain: cycle sequencer and request toggle
  // ****************************************************************
  lhp_host_st_e hst;
  logic         req_tgl, ack_meta, ack_s, ack_seen, ack_tgl;
  logic [15:0]  x_addr, x_wdata, data_q;
  logic [1:0]   x_be;
  logic         x_wr;
  logic [15:0]  rdata_q;

  // Payload stays frozen from request toggle until acknowledge
  always_ff @(posedge host_bus_clock) begin
    ack_meta <= ack_tgl;
    ack_s    <= ack_meta;
    if (!hrst_n) begin
      hst      <= HS_IDLE;
      req_tgl  <= 1'b0;
      ack_seen <= 1'b0;
      x_addr   <= 16'h0000;
      x_wdata  <= 16'h0000;
      x_be     <= 2'h0;
      x_wr     <= 1'b0;
      data_q   <= 16'h0000;
    end else begin
      case (hst)
        HS_IDLE: begin
          if (cyc) begin
            x_addr  <= s_addr;
            x_wdata <= swap16(s_data, big);
            x_be    <= next_be;
            x_wr    <= !cyc_rd;
            req_tgl <= !req_tgl;
            hst     <= HS_REQ;
          end
        end
        HS_REQ: begin
          if (ack_s != ack_seen) begin
            ack_seen <= ack_s;
            data_q   <= swap16(rdata_q, big);
            hst      <= HS_DONE;
          end
        end
        HS_DONE: begin
          if (!cyc) begin
            hst <= HS_IDLE;
          end
        end
        default: begin
          hst <= HS_IDLE;
        end
      endcase
    end
  end

  // Wait driven only while selected, low until the access completes
  assign wait_oe  = cs_act;                                                // see R20
  assign wait_n   = !((hst == HS_REQ) || (hst == HS_IDLE && cyc));         // see R15 R16
  assign data_out = data_q;
  assign data_oe  = (cs_act && hst == HS_DONE && !x_wr) ? swap2(x_be, big)
                                                       : 2'h0;             // see R14 R20

  // ****************************************************************
  // System domain: request capture and arbitration
  // ****************************************************************
  logic        req_meta, req_s, req_d, host_pend, host_go, host_cap;
  logic        hit_buf, hit_reg, cap_rd;
  logic        buf_en, reg_en;
  logic [1:0]  buf_we, reg_we;
  logic [15:0] buf_addr, buf_rd, reg_rd;

  // Refresh has priority; the host keeps waiting meanwhile
  assign host_go  = host_pend && !disp_req;                                // see R16
  assign buf_addr = disp_req ? disp_addr : x_addr;
  assign buf_en   = (disp_req && in_buf(disp_addr)) || (host_go && in_buf(x_addr)); // see R2
  assign buf_we   = (host_go && x_wr && in_buf(x_addr)) ? x_be : 2'h0;      // see R13
  assign reg_en   = host_go && in_reg(x_addr);                             // see R1
  assign reg_we   = (reg_en && x_wr) ? x_be : 2'h0;                        // see R13

  // Toggle handshake into clk_sys and back
  always_ff @(posedge clk_sys) begin
    req_meta <= req_tgl;
    req_s    <= req_meta;
    if (!rstn) begin
      req_d      <= 1'b0;
      host_pend  <= 1'b0;
      host_cap   <= 1'b0;
      hit_buf    <= 1'b0;
      hit_reg    <= 1'b0;
      cap_rd     <= 1'b0;
      ack_tgl    <= 1'b0;
      rdata_q    <= 16'h0000;
      disp_valid <= 1'b0;
    end else begin
      req_d      <= req_s;
      host_cap   <= host_go;
      hit_buf    <= in_buf(x_addr);
      hit_reg    <= in_reg(x_addr);
      cap_rd     <= !x_wr;
      disp_valid <= disp_req && in_buf(disp_addr);
      if (req_s != req_d) begin
        host_pend <= 1'b1;
      end else if (host_go) begin
        host_pend <= 1'b0;
      end
      if (host_cap) begin
        ack_tgl <= !ack_tgl;                                   // see R15
        if (cap_rd) begin
          rdata_q <= hit_buf ? buf_rd : (hit_reg ? reg_rd : 16'h0000);  // see R14
        end
      end
    end
  end

  assign disp_data = buf_rd;

  // ****************************************************************
  // Storage
  // ****************************************************************
  lhp_mem #(.DEPTH(BUF_WORDS), .AW(16)) u_buf (
    .clk   (clk_sys),
    .en    (buf_en),
    .we    (buf_we),
    .addr  (buf_addr),
    .wdata (x_wdata),
    .rdata (buf_rd)
  );

  lhp_mem #(.DEPTH(REG_WORDS), .AW(4)) u_reg (
    .clk   (clk_sys),
    .en    (reg_en),
    .we    (reg_we),
    .addr  (x_addr[3:0]),
    .wdata (x_wdata),
    .rdata (reg_rd)
  );

  // ****************************************************************
  // Assertions
  // ****************************************************************
  deselect_release_a: assert property (@(posedge host_bus_clock) disable iff (!hrst_n) // see R20
    !cs_act |-> (!wait_oe && data_oe == 2'h0))
    else $error("bus or wait driven while deselected");

  wait_hold_a: assert property (@(posedge host_bus_clock) disable iff (!hrst_n) // see R15
    (hst == HS_REQ && cs_act) |-> (wait_oe && !wait_n))
    else $error("wait released before access done");

  read_lanes_a: assert property (@(posedge host_bus_clock) disable iff (!hrst_n) // see R14
    (data_oe != 2'h0) |-> (!x_wr && hst == HS_DONE && data_oe == swap2(x_be, big)))
    else $error("data driven outside a completed read");

  strobe_68k_a: assert property (@(posedge host_bus_clock) disable iff (!hrst_n) // see R5
    (hst == HS_IDLE && cyc && mode == MODE_M68K) |=> (x_be == swap2({!$past(s_we1_n),
                                                   !$past(s_a0)}, big)))
    else $error("68k strobes mapped to wrong lanes");

  mode_frozen_a: assert property (@(posedge host_bus_clock) disable iff (!hrst_n) // see R11
    cfg_taken |=> ($stable(mode) && $stable(big)))
    else $error("bus mode changed after reset release");

  refresh_first_a: assert property (@(posedge clk_sys) disable iff (!rstn) // see R16
    (disp_req && host_pend) |=> (host_pend && !host_cap))
    else $error("host served during refresh");

  byte_write_a: assert property (@(posedge clk_sys) disable iff (!rstn) // see R13
    ((buf_we | reg_we) != 2'h0) |-> (x_wr && ((buf_we | reg_we) & ~x_be) == 2'h0))
    else $error("write to a lane without enable");

  window_map_a: assert property (@(posedge clk_sys) disable iff (!rstn) // see R1 R2
    host_go |-> (reg_en == (x_addr >= REG_BASE_WORD)
                 && (buf_we == 2'h0 || x_addr < 16'(BUF_WORDS))))
    else $error("window decode wrong");

  ack_turn_a: assert property (@(posedge clk_sys) disable iff (!rstn) // see R15
    host_go |=> ##1 (ack_tgl != $past(ack_tgl, 2)))
    else $error("acknowledge not returned two cycles after grant");

  cov_gen_write: cover property (@(posedge host_bus_clock) disable iff (!hrst_n)
    mode == MODE_GENERIC && hst == HS_REQ && x_wr ##[1:20] hst == HS_DONE);
  cov_gen_read: cover property (@(posedge host_bus_clock) disable iff (!hrst_n)
    mode == MODE_GENERIC && data_oe == 2'h3);
  cov_68k_read: cover property (@(posedge host_bus_clock) disable iff (!hrst_n)
    mode == MODE_M68K && data_oe != 2'h0);
  cov_contend: cover property (@(posedge clk_sys) disable iff (!rstn)
    disp_req && host_pend);

endmodule : lhp_host_port

// file: sim/lhp_host_model.sv
/*
  Host bus master model: drives the host pins in generic or 68k strobe mode.
  Assumes a pull-up on the wait line while the port leaves it undriven.
*/
`timescale 1ns/10ps
module lhp_host_model (
  // Host clock
  input  wire logic        host_bus_clock,
  // Pins toward the port
  output logic             chip_sel_n,
  output logic      [16:1] addr_in,
  output logic             addr_bit0,
  output logic             high_byte_write_n,
  output logic             low_byte_write_n,
  output logic             read_low_n,
  output logic             read_write_n,
  output logic             bus_status_n,
  output logic      [15:0] data_in,
  // Answers from the port
  input  wire logic [15:0] data_out,
  input  wire logic [1:0]  data_oe,
  input  wire logic        wait_n,
  input  wire logic        wait_oe
);
  // ****************************************************************
  // Idle levels and wait line
  // ****************************************************************
  logic m68k_q = 1'b0;
  logic wait_ln;

  // Pull-up holds the wait line high when the port lets go
  assign wait_ln = wait_oe ? wait_n : 1'b1; // Active low taken as is

  // Parks the bus: deselected, strobes high, data line toggled off its last value
  task automatic park;
    begin
      chip_sel_n        <= 1'b1;
      addr_bit0         <= m68k_q;
      high_byte_write_n <= 1'b1;
      low_byte_write_n  <= 1'b1;
      read_low_n        <= 1'b1;
      read_write_n      <= 1'b1;
      bus_status_n      <= m68k_q; // Held low for the generic strap
      data_in           <= ~data_in;
    end
  endtask : park

  // Park at time zero
  initial begin
    addr_in <= 16'h0000;
    park();
    data_in <= 16'h0000;
  end

  // ****************************************************************
  // One host cycle
  // ****************************************************************
  task automatic cyc(input logic m, input logic sel, input logic rd, input logic [1:0] en,
                     input logic [16:1] a, input logic [15:0] wd, input int lim,
                     output logic [15:0] rv, output logic seen, output logic ok);
    begin
      seen = 1'b0;
      ok = 1'b0;
      rv = 16'hxxxx;
      m68k_q = m;
      @(posedge host_bus_clock);
      chip_sel_n <= ~sel; // Non-boot select from window decode
      addr_in    <= a;
      data_in    <= rd ? ~data_in : wd; // Write data on both lanes, toggled on reads
      if (m) begin
        addr_bit0         <= ~en[0];
        high_byte_write_n <= ~en[1];
        read_write_n      <= rd;
        bus_status_n      <= 1'b0; // Synthesised address strobe
      end else begin
        addr_bit0         <= 1'b0;
        high_byte_write_n <= rd | ~en[1];
        low_byte_write_n  <= rd | ~en[0];
        read_write_n      <= ~rd | ~en[1];
        read_low_n        <= ~rd | ~en[0];
      end
      for (int n = 0; n < lim && !ok; n++) begin
        @(posedge host_bus_clock);
        if (wait_ln === 1'b0) begin // Cycle held by the port
          seen = 1'b1;
        end else if (seen && wait_ln === 1'b1) begin
          ok = 1'b1;
          rv = {data_oe[1] ? data_out[15:8] : 8'hzz, data_oe[0] ? data_out[7:0] : 8'hzz};
        end
      end
      park();
      repeat (3) @(posedge host_bus_clock);
    end
  endtask : cyc
endmodule : lhp_host_model

// file: sim/lcd_ctrl_host_bus_port_test.sv
/*
  Self-checking bench of the host bus port with a host master model.
  Assumes lhp_pkg and lhp_host_port compiled before it.
*/
`timescale 1ns/10ps
module lcd_ctrl_host_bus_port_test;
  import lhp_pkg::*;
  // ****************************************************************
  // Clocks, straps and wiring
  // ****************************************************************
  logic clk_sys = 1'b0, host_bus_clock = 1'b0, rstn = 1'b0;
  logic endian_config_pin = 1'b0, bus_mode_cfg_hi = 1'b1;
  logic bus_mode_cfg_mid = 1'b1, bus_mode_cfg_lo = 1'b1;
  logic disp_req = 1'b0;
  logic [15:0] disp_addr = 16'h0000;
  logic chip_sel_n, addr_bit0, high_byte_write_n, low_byte_write_n;
  logic read_low_n, read_write_n, bus_status_n, wait_n, wait_oe;
  logic mode_generic, mode_68k, big_endian, disp_valid;
  logic [16:1] addr_in;
  logic [15:0] data_in, data_out, disp_data;
  logic [1:0] data_oe;
  int err_total = 0, total_checks = 0;

  // System clock 250 MHz, host clock 30 ns
  always #2 clk_sys = ~clk_sys;
  always #15 host_bus_clock = ~host_bus_clock;

  lhp_host_port DUT (.clk_sys(clk_sys), .rstn(rstn), .host_bus_clock(host_bus_clock),
    .chip_sel_n(chip_sel_n), .addr_in(addr_in), .addr_bit0(addr_bit0),
    .high_byte_write_n(high_byte_write_n), .low_byte_write_n(low_byte_write_n),
    .read_low_n(read_low_n), .read_write_n(read_write_n), .bus_status_n(bus_status_n),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .wait_n(wait_n),
    .wait_oe(wait_oe), .endian_config_pin(endian_config_pin),
    .bus_mode_cfg_hi(bus_mode_cfg_hi), .bus_mode_cfg_mid(bus_mode_cfg_mid),
    .bus_mode_cfg_lo(bus_mode_cfg_lo), .mode_generic(mode_generic), .mode_68k(mode_68k),
    .big_endian(big_endian), .disp_req(disp_req), .disp_addr(disp_addr),
    .disp_data(disp_data), .disp_valid(disp_valid));

  lhp_host_model host (.host_bus_clock(host_bus_clock), .chip_sel_n(chip_sel_n),
    .addr_in(addr_in), .addr_bit0(addr_bit0), .high_byte_write_n(high_byte_write_n),
    .low_byte_write_n(low_byte_write_n), .read_low_n(read_low_n),
    .read_write_n(read_write_n), .bus_status_n(bus_status_n), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .wait_n(wait_n), .wait_oe(wait_oe));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic end_sim;
    begin
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask : end_sim

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    begin
      total_checks++;
      if (got !== exp) begin
        $display("BAD %s expected %h seen %h", what, exp, got);
        err_total++;
      end
    end
  endtask : chk

  // Full host cycle that must complete within its bound
  task automatic hc(input logic m, input logic rd, input logic [1:0] en,
                    input logic [16:1] a, input logic [15:0] wd, output logic [15:0] rv);
    logic seen, ok;
    begin
      host.cyc(m, 1'b1, rd, en, a, wd, 60, rv, seen, ok);
      if (ok !== 1'b1) begin
        $display("BAD host cycle expected 1 seen %b", ok);
        err_total++;
        end_sim();
      end
    end
  endtask : hc

  // Holds straps through reset and checks the latched mode
  task automatic do_reset(input logic [3:0] straps, input logic [2:0] exp_mode);
    begin
      @(posedge clk_sys);
      rstn <= 1'b0;
      {endian_config_pin, bus_mode_cfg_hi, bus_mode_cfg_mid, bus_mode_cfg_lo} <= straps;
      repeat (10) @(posedge clk_sys);
      repeat (5) @(posedge host_bus_clock);
      @(posedge clk_sys);
      rstn <= 1'b1;
      repeat (6) @(posedge host_bus_clock);
      chk("mode", {13'h0, exp_mode}, {13'h0, mode_generic, mode_68k, big_endian});
    end
  endtask : do_reset

  // One refresh read, answer one system cycle later
  task automatic disp_rd(input logic [15:0] a, input logic [15:0] exp);
    begin
      @(posedge clk_sys);
      disp_req <= 1'b1;
      disp_addr <= a;
      @(posedge clk_sys);
      disp_req <= 1'b0;
      @(negedge clk_sys);
      chk("disp_valid", 16'h0001, {15'h0, disp_valid});
      chk("disp_data", exp, disp_data);
    end
  endtask : disp_rd

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_map;
    logic [16:1] a [6];
    logic [15:0] w [6];
    logic [15:0] e [6];
    logic [15:0] rv;
    begin
      a = '{16'h0000, BUF_LAST_WORD, REG_BASE_WORD, 16'hffff, 16'(BUF_WORDS),
            REG_BASE_WORD - 16'h1};
      w = '{16'h1234, 16'hbeef, 16'h0c0d, 16'h9a9b, 16'h5a5a, 16'h3c3c};
      e = '{16'h1234, 16'hbeef, 16'h0c0d, 16'h9a9b, 16'h0000, 16'h0000};
      for (int i = 0; i < 6; i++) hc(1'b0, 1'b0, 2'h3, a[i], w[i], rv);
      for (int i = 0; i < 6; i++) begin
        hc(1'b0, 1'b1, 2'h3, a[i], 16'h0000, rv);
        chk("window read", e[i], rv);
      end
      $display("test map done");
    end
  endtask : t_map

  task automatic t_lanes_desel;
    logic [15:0] rv;
    logic seen, ok;
    begin
      hc(1'b0, 1'b0, 2'h3, 16'h0005, 16'haaaa, rv);
      hc(1'b0, 1'b0, 2'h1, 16'h0005, 16'h1155, rv);
      hc(1'b0, 1'b1, 2'h2, 16'h0005, 16'h0000, rv);
      chk("high lane read", 16'haazz, rv);
      for (int rd = 0; rd < 2; rd++) begin
        host.cyc(1'b0, 1'b0, rd[0], 2'h3, 16'h0005, 16'h0000, 12, rv, seen, ok);
        chk("deselect wait", 16'h0000, {15'h0, seen});
      end
      hc(1'b0, 1'b1, 2'h3, 16'h0005, 16'h0000, rv);
      chk("after deselect", 16'haa55, rv);
      disp_rd(16'h0005, 16'haa55);
      $display("test lanes done");
    end
  endtask : t_lanes_desel

  task automatic t_stall;
    logic [15:0] rv;
    begin
      @(posedge clk_sys);
      disp_req <= 1'b1;
      disp_addr <= 16'h0005;
      fork
        hc(1'b0, 1'b0, 2'h3, 16'h0009, 16'h7788, rv);
        begin
          repeat (20) @(posedge host_bus_clock);
          chk("stall wait", 16'h0001, {15'h0, wait_oe & ~wait_n});
          @(posedge clk_sys);
          disp_req <= 1'b0;
        end
      join
      hc(1'b0, 1'b1, 2'h3, 16'h0009, 16'h0000, rv);
      chk("stall data", 16'h7788, rv);
      $display("test stall done");
    end
  endtask : t_stall

  task automatic t_refused;
    logic [15:0] rv;
    logic seen, ok;
    begin
      do_reset(4'h5, 3'h0);
      host.cyc(1'b0, 1'b1, 1'b0, 2'h3, 16'h0005, 16'h4444, 15, rv, seen, ok);
      chk("unsupported mode wait", 16'h0000, {15'h0, seen});
      do_reset(4'hf, 3'h5);
      hc(1'b0, 1'b1, 2'h3, 16'h0005, 16'h0000, rv);
      chk("big endian read", 16'h55aa, rv);
      $display("test refused done");
    end
  endtask : t_refused

  task automatic t_68k;
    logic [15:0] rv;
    begin
      do_reset(4'hb, 3'h3);
      hc(1'b1, 1'b0, 2'h3, 16'h0007, 16'h12ab, rv);
      disp_rd(16'h0007, 16'hab12);
      hc(1'b1, 1'b0, 2'h2, 16'h0007, 16'h5600, rv);
      hc(1'b1, 1'b1, 2'h3, 16'h0007, 16'h0000, rv);
      chk("68k word read", 16'h56ab, rv);
      hc(1'b1, 1'b1, 2'h1, 16'h0007, 16'h0000, rv);
      chk("68k low strobe", 16'hzzab, rv);
      $display("test 68k done");
    end
  endtask : t_68k

  // Main sequence
  initial begin
    do_reset(4'h7, 3'h4);
    t_map();
    t_lanes_desel();
    t_stall();
    t_refused();
    t_68k();
    end_sim();
  end
endmodule : lcd_ctrl_host_bus_port_test
